// file: common/ifx_map.vh
// Constants for the instruction fetch, microsequencer and mini translation front end.
// Summary of operation
// - Prefetch queue holds eight bytes, FIFO order.
// - Prefetch reads when four bytes free and bus free.
// - Decode info goes to execution and accelerator.
// - Sequencer computes next microaddress, two exceptions.
// - New macroinstruction selects microroutine entry address.
// - Microaddress driven in clock first half.
// - Fresh microword ready every 200 ns cycle.
// - Sixteen general registers with address adder.
// - Virtual addresses go to mini translation buffer.
// - Five entries: four data, one instruction.
// - Each entry holds tag and page map entry.
// - Page frame number 21 bits, 512-byte pages.
// - Valid hit drives physical address without delay.
// - Miss with backup hit costs 200 ns.
`ifndef IFX_MAP_VH
`define IFX_MAP_VH
`define IFX_CLK_NS 100
`define IFX_CYCLE_NS 200
`define IFX_BTB_DELAY_NS 200
`define IFX_BTB_DELAY_CYC ((`IFX_BTB_DELAY_NS + `IFX_CLK_NS - 1) / `IFX_CLK_NS)
`define IFX_PFQ_DEPTH 8
`define IFX_UWORD_W 40
`define IFX_UADDR_W 14
`define IFX_NREGS 16
`define IFX_NDATA_ENT 4
`define IFX_NENT 5
`define IFX_IENT_IDX 4
`define IFX_PFN_W 21
`define IFX_OFS_W 9
`define IFX_VA_W 32
`define IFX_PA_W 30
`define IFX_VPN_W 23
`define IFX_BTB_ENTRIES 512
`endif

// file: core/ifx_front_end.v
// Instruction prefetch, microsequencer, execution registers and mini translation buffer.
`timescale 1ns/10ps
`default_nettype none
`include "ifx_map.vh"
module ifx_front_end
(
    // Clock and reset
    input wire mclk_in,
    input wire rstn_in,
    // Shared data/address bus read path for prefetch
    input wire bus_busy_in,
    input wire pf_ack_in,
    input wire [31:0] pf_data_in,
    input wire [31:0] pf_addr_in,
    input wire pf_flush_in,
    output wire pf_req_out,
    output reg [31:0] pf_addr_out,
    // Decode information to execution unit and accelerator
    input wire decode_in,
    output reg [7:0] opcode_exec_out,
    output reg [7:0] opcode_fpa_out,
    output reg decode_valid_out,
    // Microword bus
    input wire [`IFX_UWORD_W-1:0] microword_bus_in,
    input wire [`IFX_UADDR_W-1:0] entry_addr_in,
    input wire first_part_done_in,
    input wire [`IFX_UADDR_W-1:0] fpd_addr_in,
    output reg [`IFX_UADDR_W-1:0] microword_bus_addr_out,
    output reg microword_bus_phase_out,
    output reg [`IFX_UWORD_W-1:0] uword_out,
    // Execution unit register write and address generation
    input wire [3:0] wr_sel_in,
    input wire wr_en_in,
    input wire [31:0] wr_data_in,
    input wire [3:0] base_sel_in,
    input wire [31:0] disp_in,
    input wire va_req_in,
    input wire istream_in,
    input wire [1:0] dent_sel_in,
    // Mini translation buffer load from backup buffer
    input wire btb_hit_in,
    input wire [`IFX_PFN_W-1:0] btb_pfn_in,
    // Shared data/address bus physical address out
    output reg [`IFX_PA_W-1:0] shared_data_addr_bus_out,
    output reg pa_valid_out,
    output reg btb_lookup_out,
    output reg [`IFX_VA_W-1:0] btb_va_out
);
    // Prefetch queue storage.
    reg [7:0] pfq_mem [0:`IFX_PFQ_DEPTH-1];
    reg [2:0] pfq_wr_q;
    reg [2:0] pfq_rd_q;
    reg [3:0] pfq_cnt_q;
    reg pf_pend_q;
    reg [31:0] pf_next_q;
    // A word read lands four bytes at once, so a read starts only while four slots are free.
    wire pfq_room = (pfq_cnt_q <= 4'h4);
    wire pfq_pop = decode_in && (pfq_cnt_q != 4'h0);

    // The request is combinational so the bus side sees it in the very cycle the conditions hold.
    assign pf_req_out = rstn_in && pfq_room && !bus_busy_in && !pf_pend_q && !pf_flush_in;

    always @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            pfq_wr_q <= 3'h0;
            pfq_rd_q <= 3'h0;
            pfq_cnt_q <= 4'h0;
            pf_pend_q <= 1'b0;
            pf_next_q <= 32'h0;
            pf_addr_out <= 32'h0;
        end
        else if (pf_flush_in)
        begin
            pfq_wr_q <= 3'h0;
            pfq_rd_q <= 3'h0;
            pfq_cnt_q <= 4'h0;
            pf_pend_q <= 1'b0;
            pf_next_q <= pf_addr_in;
            pf_addr_out <= pf_addr_in;
        end
        else
        begin
            if (pf_req_out)
            begin
                pf_pend_q <= 1'b1;
                pf_addr_out <= pf_next_q;
            end
            if (pf_ack_in && pf_pend_q)
            begin
                // Four bytes land at once; the room check kept space for all of them.
                pf_pend_q <= 1'b0;
                pf_next_q <= pf_next_q + 32'h4;
                pfq_wr_q <= pfq_wr_q + 3'h4;
            end
            if (pfq_pop)
                pfq_rd_q <= pfq_rd_q + 3'h1;
            pfq_cnt_q <= pfq_cnt_q + ((pf_ack_in && pf_pend_q) ? 4'h4 : 4'h0) - (pfq_pop ? 4'h1 : 4'h0);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pfq_wr
            always @(posedge mclk_in)
            begin
                if (pf_ack_in && pf_pend_q && !pf_flush_in)
                    pfq_mem[pfq_wr_q + gi[2:0]] <= pf_data_in[8*gi+7:8*gi];
            end
        end
    endgenerate

    always @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            opcode_exec_out <= 8'h0;
            opcode_fpa_out <= 8'h0;
            decode_valid_out <= 1'b0;
        end
        else
        begin
            decode_valid_out <= pfq_pop && !pf_flush_in;
            if (pfq_pop)
            begin
                opcode_exec_out <= pfq_mem[pfq_rd_q];
                opcode_fpa_out <= pfq_mem[pfq_rd_q];
            end
        end
    end

    // Two 100 ns phases make one 200 ns processor cycle; phase 0 is the address half.
    reg [`IFX_UADDR_W-1:0] upc_q;
    reg [`IFX_UADDR_W-1:0] unext_d;
    reg entry_pend_q;

    // First-part-done wins over a new entry so an interrupted instruction resumes where it stopped.
    always @*
    begin
        if (first_part_done_in)
            unext_d = fpd_addr_in;
        else if (decode_valid_out || entry_pend_q)
            unext_d = entry_addr_in;
        else
            unext_d = upc_q + {{(`IFX_UADDR_W-1){1'b0}}, 1'b1};
    end

    always @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            microword_bus_phase_out <= 1'b0;
            microword_bus_addr_out <= {`IFX_UADDR_W{1'b0}};
            upc_q <= {`IFX_UADDR_W{1'b0}};
            uword_out <= {`IFX_UWORD_W{1'b0}};
            entry_pend_q <= 1'b0;
        end
        else
        begin
            microword_bus_phase_out <= ~microword_bus_phase_out;
            if (microword_bus_phase_out)
            begin
                // End of the data half: take the word, then present the next address in the first half.
                upc_q <= unext_d;
                microword_bus_addr_out <= unext_d;
                uword_out <= microword_bus_in;
                entry_pend_q <= 1'b0;
            end
            else
            begin
                // A decode that lands mid-cycle is held until the next address edge, else it would be lost.
                entry_pend_q <= entry_pend_q | decode_valid_out;
            end
        end
    end

    // Execution unit general registers and address adder.
    reg [31:0] gpr_q [0:`IFX_NREGS-1];
    generate
        for (gi = 0; gi < `IFX_NREGS; gi = gi + 1)
        begin : g_gpr
            always @(posedge mclk_in)
            begin
                if (!rstn_in)
                    gpr_q[gi] <= 32'h0;
                else if (wr_en_in && wr_sel_in == gi[3:0])
                    gpr_q[gi] <= wr_data_in;
            end
        end
    endgenerate
    wire [31:0] va = gpr_q[base_sel_in] + disp_in;

    // Mini translation buffer: entries 0..3 data, entry 4 instruction.
    reg [`IFX_NENT-1:0] ent_valid_q;
    reg [`IFX_VPN_W-1:0] ent_tag_q [0:`IFX_NENT-1];
    reg [`IFX_PFN_W-1:0] ent_pfn_q [0:`IFX_NENT-1];
    wire [2:0] ent_idx = istream_in ? 3'h4 : {1'b0, dent_sel_in};
    wire [`IFX_VPN_W-1:0] va_vpn = va[`IFX_VA_W-1:`IFX_OFS_W];
    wire mtb_hit = ent_valid_q[ent_idx] && (ent_tag_q[ent_idx] == va_vpn);
    reg [`IFX_VA_W-1:0] miss_va_q;
    reg [2:0] miss_idx_q;
    reg [1:0] miss_cnt_q;
    reg miss_q;
    // The counter preloads one short because the lookup cycle itself is part of the wait.
    localparam integer MISS_WAIT_I = `IFX_BTB_DELAY_CYC - 1;
    localparam [1:0] MISS_WAIT = MISS_WAIT_I[1:0];

    generate
        for (gi = 0; gi < `IFX_NENT; gi = gi + 1)
        begin : g_mtb
            always @(posedge mclk_in)
            begin
                if (!rstn_in)
                begin
                    ent_valid_q[gi] <= 1'b0;
                    ent_tag_q[gi] <= {`IFX_VPN_W{1'b0}};
                    ent_pfn_q[gi] <= {`IFX_PFN_W{1'b0}};
                end
                else if (miss_q && btb_hit_in && miss_idx_q == gi[2:0])
                begin
                    ent_valid_q[gi] <= 1'b1;
                    ent_tag_q[gi] <= miss_va_q[`IFX_VA_W-1:`IFX_OFS_W];
                    ent_pfn_q[gi] <= btb_pfn_in;
                end
            end
        end
    endgenerate

    always @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            miss_q <= 1'b0;
            miss_cnt_q <= 2'h0;
            miss_va_q <= 32'h0;
            miss_idx_q <= 3'h0;
            pa_valid_out <= 1'b0;
            shared_data_addr_bus_out <= {`IFX_PA_W{1'b0}};
            btb_lookup_out <= 1'b0;
            btb_va_out <= 32'h0;
        end
        else
        begin
            pa_valid_out <= 1'b0;
            btb_lookup_out <= 1'b0;
            if (miss_q)
            begin
                // The backup buffer answer is held off so a refill costs the full 200 ns.
                if (miss_cnt_q != 2'h0)
                    miss_cnt_q <= miss_cnt_q - 2'h1;
                else if (btb_hit_in)
                begin
                    miss_q <= 1'b0;
                    pa_valid_out <= 1'b1;
                    shared_data_addr_bus_out <= {btb_pfn_in, miss_va_q[`IFX_OFS_W-1:0]};
                end
                else
                    btb_lookup_out <= 1'b1;
            end
            else if (va_req_in && mtb_hit)
            begin
                pa_valid_out <= 1'b1;
                shared_data_addr_bus_out <= {ent_pfn_q[ent_idx], va[`IFX_OFS_W-1:0]};
            end
            else if (va_req_in)
            begin
                miss_q <= 1'b1;
                miss_cnt_q <= MISS_WAIT;
                miss_va_q <= va;
                miss_idx_q <= ent_idx;
                btb_lookup_out <= 1'b1;
                btb_va_out <= va;
            end
        end
    end
endmodule // ifx_front_end
`default_nettype wire

// file: dv/ifx_cstore.sv
// Control store model on the microword bus.
`timescale 1ns/10ps
`default_nettype none
module ifx_cstore
(
    input wire logic [13:0] addr_in,
    input wire logic phase_in,
    output logic [39:0] word_out
);
    // Word is valid only in the data half; the other half shows its inverse so a mistimed capture shows.
    assign word_out = {40{~phase_in}} ^ {addr_in, ~addr_in, 12'ha5c};
endmodule // ifx_cstore
`default_nettype wire

// file: dv/ifx_front_end_test.sv
// Self-checking bench for the front end.
`timescale 1ns/10ps
`default_nettype none
module ifx_front_end_test;
    logic mclk_in = 0, rstn_in = 0, bus_busy_in = 1, pf_ack_in = 0, pf_flush_in = 0, decode_in = 0;
    logic first_part_done_in = 0, wr_en_in = 0, va_req_in = 0, istream_in = 0, btb_hit_in = 1;
    logic [31:0] pf_data_in = 0, pf_addr_in = 0, wr_data_in = 0, disp_in = 0, w, regs [0:15];
    logic [13:0] entry_addr_in = 0, fpd_addr_in = 0, microword_bus_addr_out;
    logic [3:0] wr_sel_in = 0, base_sel_in = 0, kb;
    logic [1:0] dent_sel_in = 0;
    logic [20:0] btb_pfn_in = 0, pf [0:4];
    logic [22:0] pv [0:4];
    logic [7:0] opcode_exec_out, opcode_fpa_out, eb, n, nreq = 0;
    wire [39:0] microword_bus_in, uword_out;
    wire [31:0] pf_addr_out, btb_va_out;
    wire [29:0] shared_data_addr_bus_out;
    wire pf_req_out, decode_valid_out, microword_bus_phase_out, pa_valid_out, btb_lookup_out;
    integer n_mismatch = 0, n_tests = 0, seed = 32'h5d6ee529, i, j;
    logic [7:0] bq [$];
    logic [29:0] pq [$];
    always #50 mclk_in = ~mclk_in;
    ifx_front_end DUT (.*);
    ifx_cstore u_cs (.addr_in(microword_bus_addr_out), .phase_in(microword_bus_phase_out), .word_out(microword_bus_in));
    task automatic chk(input string what, input logic [39:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wait_ua(input logic [13:0] a);
        n = 0;
        while (microword_bus_addr_out !== a && n < 8)
        begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk("microaddress", microword_bus_addr_out, a);
    endtask
    task automatic xl(input int ent, input bit miss);
        logic [8:0] off;
        off = $random(seed);
        kb = $random(seed);
        @(posedge mclk_in);
        base_sel_in <= kb;
        disp_in <= {pv[ent], off} - regs[kb];
        istream_in <= ent == 4;
        dent_sel_in <= ent[1:0];
        // A stale backup answer on hits shows whether the stored entry is used.
        btb_pfn_in <= miss ? pf[ent] : ~pf[ent];
        // Entry 2 gets its backup answer one cycle late, so the lookup must be retried.
        btb_hit_in <= !(miss && ent == 2);
        va_req_in <= 1;
        pq.push_back({pf[ent], off});
        @(posedge mclk_in);
        va_req_in <= 0;
        n = 1;
        #1 chk("lookup", btb_lookup_out, miss);
        if (miss)
            chk("lookup address", btb_va_out, {pv[ent], off});
        while (pa_valid_out !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            #1 n++;
            if (miss && ent == 2 && n == 3)
                btb_hit_in <= 1;
        end
        chk("latency", n, miss ? (ent == 2 ? 4 : 3) : 1);
    endtask
    always @(posedge mclk_in)
    begin
        if (decode_valid_out === 1'b1)
        begin
            eb = bq.pop_front();
            chk("exec byte", opcode_exec_out, eb);
            chk("fpa byte", opcode_fpa_out, eb);
        end
        if (pa_valid_out === 1'b1)
            chk("physical", shared_data_addr_bus_out, pq.pop_front());
    end
    always
    begin
        @(posedge mclk_in);
        if (pf_req_out === 1'b1)
        begin
            repeat (2) @(posedge mclk_in);
            w = $random(seed);
            pf_data_in <= w;
            pf_ack_in <= 1;
            for (j = 0; j < 4; j++)
                bq.push_back(w[8*j+:8]);
            nreq++;
            @(posedge mclk_in);
            pf_ack_in <= 0;
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge mclk_in);
            regs[i] = $random(seed);
            wr_sel_in <= i;
            wr_data_in <= regs[i];
            wr_en_in <= 1;
        end
        @(posedge mclk_in);
        wr_en_in <= 0;
        for (i = 0; i < 5; i++)
        begin
            pv[i] = $random(seed);
            pf[i] = $random(seed);
            xl(i, 1);
        end
        for (i = 0; i < 5; i++)
            xl(i, 0);
        $display("translation test done");
        @(posedge mclk_in);
        pf_addr_in <= $random(seed);
        pf_flush_in <= 1;
        @(posedge mclk_in);
        pf_flush_in <= 0;
        bus_busy_in <= 0;
        repeat (2) @(posedge mclk_in);
        chk("fetch address", pf_addr_out, pf_addr_in);
        repeat (30) @(posedge mclk_in);
        chk("fetch count", nreq, 2);
        for (i = 0; i < 40; i++)
        begin
            @(posedge mclk_in);
            decode_in <= 1;
            bus_busy_in <= $random(seed);
        end
        @(posedge mclk_in);
        decode_in <= 0;
        bus_busy_in <= 0;
        $display("prefetch test done");
        // Let the queue refill so the next decode surely pops a byte.
        repeat (8) @(posedge mclk_in);
        entry_addr_in <= $random(seed);
        decode_in <= 1;
        @(posedge mclk_in);
        decode_in <= 0;
        wait_ua(entry_addr_in);
        wait_ua(entry_addr_in + 14'h1);
        fpd_addr_in <= $random(seed);
        first_part_done_in <= 1;
        @(posedge mclk_in);
        wait_ua(fpd_addr_in);
        first_part_done_in <= 0;
        repeat (2) @(posedge mclk_in);
        #1 chk("microword", uword_out, {fpd_addr_in, ~fpd_addr_in, 12'ha5c});
        repeat (12) @(posedge mclk_in);
        $display("microsequencer test done");
        end_sim;
    end
endmodule // ifx_front_end_test
`default_nettype wire

// file: dv/ifx_properties.sv
// Port checks for the front end.
`timescale 1ns/10ps
`default_nettype none
module ifx_properties
(
    // Clock, reset, prefetch, decode
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic bus_busy_in,
    input wire logic pf_flush_in,
    input wire logic pf_req_out,
    input wire logic decode_in,
    input wire logic decode_valid_out,
    input wire logic [7:0] opcode_exec_out,
    input wire logic [7:0] opcode_fpa_out,
    // Microword bus and translation
    input wire logic [39:0] microword_bus_in,
    input wire logic microword_bus_phase_out,
    input wire logic [39:0] uword_out,
    input wire logic va_req_in,
    input wire logic [20:0] btb_pfn_in,
    input wire logic btb_lookup_out,
    input wire logic pa_valid_out,
    input wire logic [29:0] shared_data_addr_bus_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_fetch_bus_free: assert property (pf_req_out |-> !bus_busy_in && !pf_flush_in)
        else $error("fetch started while bus taken");
    a_fetch_single: assert property (pf_req_out |=> !pf_req_out)
        else $error("second fetch while one pending");
    a_phase_toggle: assert property ($past(rstn_in) |-> microword_bus_phase_out != $past(microword_bus_phase_out))
        else $error("microword phase did not toggle");
    a_uword_capture: assert property (microword_bus_phase_out |=> uword_out == $past(microword_bus_in))
        else $error("microword not captured");
    a_decode_both: assert property (decode_valid_out |-> opcode_exec_out == opcode_fpa_out)
        else $error("decode copies differ");
    a_decode_cause: assert property (decode_valid_out |-> $past(decode_in))
        else $error("decode without request");
    a_miss_delay: assert property ($rose(btb_lookup_out) && !$past(btb_lookup_out, 2) |-> !pa_valid_out [*2])
        else $error("miss answered too early");
    a_lookup_cause: assert property ($rose(btb_lookup_out) && !$past(btb_lookup_out, 2) |-> $past(va_req_in))
        else $error("lookup without address request");
    a_miss_frame: assert property (pa_valid_out && ($past(btb_lookup_out) || $past(btb_lookup_out, 2))
        |-> shared_data_addr_bus_out[29:9] == $past(btb_pfn_in))
        else $error("miss frame number wrong");
endmodule // ifx_properties
bind ifx_front_end ifx_properties u_props (.*);
`default_nettype wire
